// File: pkg/smisci_pkg.sv
// Constants and types shared by the SMI/SCI event generator
package smisci_pkg;
  localparam int NEV = 20;
  localparam int NGPI = 8;
  localparam int NSMI = 4;
  localparam int NLINE = 7;
  localparam int NINT = 2;
  // Event status/enable bit positions
  localparam int EV_OVR = 0;
  localparam int EV_RTC = 1;
  localparam int EV_PWB = 2;
  localparam int EV_GBL = 3;
  localparam int EV_TMR = 4;
  localparam int EV_PME = 5;
  localparam int EV_BAT = 6;
  localparam int EV_SWG = 7;
  localparam int EV_GPI = 8;
  localparam int EV_SMI = 16;
  localparam logic [NEV-1:0] DUAL_MASK = 20'h000f6;
  localparam logic [NEV-1:0] SCI_ONLY_MASK = 20'h00009;
  localparam logic [NEV-1:0] SMI_ONLY_MASK = 20'hf0000;
  localparam logic [NEV-1:0] EN_FORCED = 20'h00001;
  // Register byte offsets
  localparam logic [7:0] OFS_STS = 8'h00;
  localparam logic [7:0] OFS_EN = 8'h04;
  localparam logic [7:0] OFS_CTL = 8'h08;
  localparam logic [7:0] OFS_ROUTE = 8'h0c;
  localparam logic [7:0] OFS_ISTS = 8'h10;
  localparam logic [7:0] OFS_IMSK = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  // Control register fields
  localparam int CTL_SCI = 0;
  localparam int CTL_GSMI = 1;
  localparam int CTL_REARM = 2;
  localparam int CTL_SWGPE = 3;
  localparam int CTL_APIC = 4;
  localparam int CTL_IRQ = 8;
  // Interrupt status fields
  localparam int INT_SMI = 0;
  localparam int INT_SCI = 1;
  // GPI routing code that selects SCI
  localparam logic [1:0] ROUTE_SCI = 2'h2;
  // SCI line codes; codes from LINE_SHARED up are shared with PCI
  localparam logic [2:0] LINE_IRQ9 = 3'h0;
  localparam logic [2:0] LINE_IRQ11 = 3'h2;
  localparam logic [2:0] LINE_SHARED = 3'h3;
  localparam logic [2:0] LINE_IRQ23 = 3'h6;
  localparam logic [NLINE-1:0] LINE_IDLE = 7'h78;
  // Power state codes
  localparam logic [1:0] PM_S0 = 2'h0;
  localparam logic [1:0] PM_S0IX = 2'h1;
  localparam logic [1:0] PM_S4 = 2'h2;
  localparam logic [1:0] PM_S5 = 2'h3;
  // SMI delivery states, Gray along armed -> send -> hold
  typedef enum logic [1:0] {
    SMI_ARMED = 2'h0,
    SMI_SEND = 2'h1,
    SMI_HOLD = 2'h3
  } smisci_smi_t;
  localparam smisci_smi_t SMI_RST = SMI_ARMED;
endpackage

// File: rtl/smisci_sticky.sv
// Sticky status bits, write-one-to-clear, set beats clear
`timescale 1ns/10ps
`default_nettype none
module smisci_sticky #(
  parameter int W = 1
) (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Sync reset
  input wire logic [W-1:0] set, // Event pulses
  input wire logic [W-1:0] clr, // Write-one clears
  output logic [W-1:0] q // Status bits
);
  typedef struct packed {
    logic [W-1:0] bits;
  } smisci_stk_t;
  smisci_stk_t s_q, s_d;
  always_comb begin
    s_d.bits = (s_q.bits & ~clr) | set;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign q = s_q.bits;
endmodule
`default_nettype wire

// File: rtl/smisci_router.sv
// Steers the SCI level onto one legacy or shared IRQ line
`timescale 1ns/10ps
`default_nettype none
module smisci_router (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Sync reset
  input wire logic level, // SCI active
  input wire logic apic_en, // APIC routing allowed
  input wire logic [2:0] sel, // Line code
  output logic [smisci_pkg::NLINE-1:0] lines // IRQ9..11, IRQ20..23
);
  import smisci_pkg::*;
  typedef struct packed {
    logic [NLINE-1:0] lines;
  } smisci_rt_t;
  smisci_rt_t r_q, r_d;
  logic [2:0] eff;
  always_comb begin
    r_d.lines = LINE_IDLE;
    eff = sel;
    // Legacy mode only knows IRQ 9..11
    if (!apic_en && sel > LINE_IRQ11) begin
      eff = LINE_IRQ9;
    end
    // Shared lines idle high and assert low
    if (level && eff <= LINE_IRQ23) begin
      r_d.lines[eff] = ~LINE_IDLE[eff];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r_q.lines <= LINE_IDLE;
    end else begin
      r_q <= r_d;
    end
  end
  assign lines = r_q.lines;
endmodule
`default_nettype wire

// File: rtl/smisci_top.sv
// SMI/SCI event generator with APB register access
// Function
// - An enabled SMI event while the re-arm flag is set clears it and sends one SMI.
// - After an SMI, events stay latched and no SMI is sent until software sets the re-arm flag again.
// - SMI goes out as a sideband wire message, never on a dedicated pin.
// - SCI is a level that holds while any enabled SCI source is active.
// - Without APIC the SCI goes to one of IRQ 9, 10 or 11.
// - With APIC it may go to IRQ 9..11 or 20..23, polarity set by PCI sharing.
// - Each source has its own status bit and, except the always-enabled override, its own enable bit.
// - Dual events give SCI if SCI is selected, else SMI if SMI is on, else none.
// - A GPI gives SCI only with route 10b, its enable and SCI selected; never SMI.
// - Battery low blocks wake from S4/S5 and is an SMI event in S0.
// - Status bits set on their event whatever the enable says.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module smisci_top (
  input wire logic core_clk, // 100 MHz clock
  input wire logic reset_n, // Sync reset
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic button_override, // Override pulse
  input wire logic rtc_alarm, // RTC alarm pulse
  input wire logic power_button, // Button press pulse
  input wire logic global_release, // Global release pulse
  input wire logic pm_timer_overflow, // Timer overflow pulse
  input wire logic bus0_pme, // Bus 0 PME pulse
  input wire logic battery_low_n, // Battery low level
  input wire logic [smisci_pkg::NGPI-1:0] gpi, // GPI levels
  input wire logic [smisci_pkg::NSMI-1:0] smi_event, // SMI-only pulses
  input wire logic [1:0] pm_state, // Power state
  input wire logic wake_request, // Wake source level
  output logic wake_allowed, // Gated wake
  output logic sideband_wire_message, // SMI message valid
  input wire logic sideband_ready, // Message taken
  output logic [smisci_pkg::NLINE-1:0] sci_lines, // IRQ lines
  output logic irq // Interrupt level
);
  import smisci_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic pslverr;
    logic [NEV-1:0] en;
    logic sci_select;
    logic global_smi_enable;
    logic apic;
    logic [2:0] line;
    logic [2*NGPI-1:0] gpi_route_select;
    logic [NINT-1:0] imsk;
    smisci_smi_t smi;
    logic bat_prev;
    logic [NGPI-1:0] gpi_prev;
    logic sci_prev;
    logic wake;
    logic irq;
  } smisci_st_t;

  localparam smisci_st_t ST_RST = '{
    prdata: 32'h0000_0000,
    pslverr: 1'b0,
    en: '0,
    sci_select: 1'b0,
    global_smi_enable: 1'b0,
    apic: 1'b0,
    line: LINE_IRQ9,
    gpi_route_select: '0,
    imsk: '0,
    smi: SMI_RST,
    bat_prev: 1'b1,
    gpi_prev: '0,
    sci_prev: 1'b0,
    wake: 1'b0,
    irq: 1'b0
  };

  smisci_st_t q, d;
  logic [NEV-1:0] ev_set, ev_clr, ev_sts;
  logic [NINT-1:0] int_set, int_clr, int_sts;
  logic [NEV-1:0] act, dual_smi;
  logic [NGPI-1:0] gpi_sci;
  logic wr, setup, sci_lvl, smi_cause, smi_done;
  logic rearm_wr, swgpe_wr, in_s0, in_s45;

  smisci_sticky #(.W(NEV)) u_ev_sts (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .set(ev_set),
    .clr(ev_clr),
    .q(ev_sts)
  );

  smisci_sticky #(.W(NINT)) u_int_sts (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .set(int_set),
    .clr(int_clr),
    .q(int_sts)
  );

  smisci_router u_router (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .level(sci_lvl),
    .apic_en(q.apic),
    .sel(q.line),
    .lines(sci_lines)
  );

  always_comb begin
    d = q;
    wr = psel & penable & pwrite;
    setup = psel & ~penable;
    rearm_wr = wr && paddr == OFS_CTL && pwdata[CTL_REARM];
    swgpe_wr = wr && paddr == OFS_CTL && pwdata[CTL_SWGPE];
    in_s0 = pm_state == PM_S0;
    in_s45 = pm_state == PM_S4 || pm_state == PM_S5;

    // Status capture ignores the enables
    ev_set = '0;
    ev_set[EV_OVR] = button_override;
    ev_set[EV_RTC] = rtc_alarm;
    ev_set[EV_PWB] = power_button;
    ev_set[EV_GBL] = global_release;
    ev_set[EV_TMR] = pm_timer_overflow;
    ev_set[EV_PME] = bus0_pme;
    ev_set[EV_BAT] = q.bat_prev & ~battery_low_n;
    ev_set[EV_SWG] = swgpe_wr;
    ev_set[EV_GPI +: NGPI] = gpi & ~q.gpi_prev;
    ev_set[EV_SMI +: NSMI] = smi_event;
    ev_clr = (wr && paddr == OFS_STS) ? pwdata[NEV-1:0] : '0;
    d.bat_prev = battery_low_n;
    d.gpi_prev = gpi;

    // Active only while status is set and enabled
    act = ev_sts & (q.en | EN_FORCED);
    for (int i = 0; i < NGPI; i++) begin
      gpi_sci[i] = act[EV_GPI + i]
        && q.gpi_route_select[2*i +: 2] == ROUTE_SCI;
    end
    dual_smi = act & DUAL_MASK;
    // Battery low counts for SMI only when running
    if (!in_s0) begin
      dual_smi[EV_BAT] = 1'b0;
    end

    // SCI select wins over SMI for dual events
    sci_lvl = q.sci_select
      & (|(act & (DUAL_MASK | SCI_ONLY_MASK)) | |gpi_sci);
    smi_cause = q.global_smi_enable
      & ((~q.sci_select & |dual_smi) | |(act & SMI_ONLY_MASK));
    d.sci_prev = sci_lvl;

    // SMI delivery; flag reads set only while armed
    smi_done = q.smi == SMI_SEND && sideband_ready;
    unique case (q.smi)
      SMI_ARMED: begin
        if (smi_cause) begin
          d.smi = SMI_SEND;
        end
      end
      SMI_SEND: begin
        if (sideband_ready) begin
          d.smi = SMI_HOLD;
        end
      end
      SMI_HOLD: begin
        // Events stay latched; re-arm resends if any remain
        if (rearm_wr) begin
          d.smi = SMI_ARMED;
        end
      end
      default: begin
        d.smi = SMI_ARMED;
      end
    endcase

    // Host interrupt bookkeeping
    int_set = '0;
    int_set[INT_SMI] = smi_done;
    int_set[INT_SCI] = sci_lvl & ~q.sci_prev;
    int_clr = (wr && paddr == OFS_ISTS) ? pwdata[NINT-1:0] : '0;
    d.irq = |(int_sts & q.imsk);

    // No wake from S4/S5 on a low battery
    d.wake = wake_request & ~(in_s45 & ~battery_low_n);

    // Register writes
    if (wr) begin
      unique case (paddr)
        OFS_EN: begin
          d.en = pwdata[NEV-1:0];
        end
        OFS_CTL: begin
          d.sci_select = pwdata[CTL_SCI];
          d.global_smi_enable = pwdata[CTL_GSMI];
          d.apic = pwdata[CTL_APIC];
          d.line = pwdata[CTL_IRQ +: 3];
        end
        OFS_ROUTE: begin
          d.gpi_route_select = pwdata[2*NGPI-1:0];
        end
        OFS_IMSK: begin
          d.imsk = pwdata[NINT-1:0];
        end
        default: begin
        end
      endcase
    end

    // Read data prepared in setup so access needs no wait
    if (setup) begin
      d.prdata = 32'h0000_0000;
      d.pslverr = 1'b0;
      unique case (paddr)
        OFS_STS: begin
          d.prdata[NEV-1:0] = ev_sts;
        end
        OFS_EN: begin
          d.prdata[NEV-1:0] = q.en;
        end
        OFS_CTL: begin
          d.prdata[CTL_SCI] = q.sci_select;
          d.prdata[CTL_GSMI] = q.global_smi_enable;
          d.prdata[CTL_REARM] = q.smi == SMI_ARMED;
          d.prdata[CTL_APIC] = q.apic;
          d.prdata[CTL_IRQ +: 3] = q.line;
        end
        OFS_ROUTE: begin
          d.prdata[2*NGPI-1:0] = q.gpi_route_select;
        end
        OFS_ISTS: begin
          d.prdata[NINT-1:0] = int_sts;
        end
        OFS_IMSK: begin
          d.prdata[NINT-1:0] = q.imsk;
        end
        OFS_STATE: begin
          d.prdata[0] = sci_lvl;
          d.prdata[2:1] = q.smi;
          d.prdata[4:3] = pm_state;
          d.prdata[5] = battery_low_n;
          d.prdata[6] = q.wake;
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
      // Writes return zero; only the error flag survives
      if (pwrite) begin
        d.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // Zero-wait slave: every access completes in one cycle
  assign pready = 1'b1;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr & psel & penable;
  assign sideband_wire_message = q.smi == SMI_SEND;
  assign wake_allowed = q.wake;
  assign irq = q.irq;
endmodule
`default_nettype wire

// File: dv/smisci_props.sv
// Port-level assertions for the SMI/SCI event generator
`timescale 1ns/10ps
`default_nettype none
module smisci_props (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Sync reset
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Error
  input wire logic [1:0] pm_state, // Power state
  input wire logic battery_low_n, // Battery low
  input wire logic wake_request, // Wake in
  input wire logic wake_allowed, // Wake out
  input wire logic sideband_wire_message, // SMI valid
  input wire logic sideband_ready, // SMI taken
  input wire logic [smisci_pkg::NLINE-1:0] sci_lines // IRQ lines
);
  import smisci_pkg::*;
  wire logic m = sideband_wire_message;
  wire logic r = sideband_ready;
  wire logic setup = psel && !penable;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  smi_hold_a: assert property (m && !r |=> m)
    else $error("SMI message left before it was taken");
  smi_drop_a: assert property (m && r |=> !m)
    else $error("SMI message stayed after handshake");
  sci_line_a: assert property ($onehot0(sci_lines ^ LINE_IDLE))
    else $error("SCI on more than one line");
  wake_block_a: assert property (
    pm_state[1] && !battery_low_n |=> !wake_allowed)
    else $error("Wake passed with battery low");
  wake_pass_a: assert property (
    wake_request && !pm_state[1] |=> wake_allowed)
    else $error("Wake lost outside S4/S5");
  wake_none_a: assert property (!wake_request |=> !wake_allowed)
    else $error("Wake without request");
  bad_addr_a: assert property (
    setup && paddr > 8'h18 |=> pslverr && prdata == 0)
    else $error("Unmapped access not refused");
  wr_data_a: assert property (setup && pwrite |=> prdata == 0)
    else $error("Read data during write");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("Error outside access phase");
  cover property (m && r);
  cover property (sci_lines != LINE_IDLE);
  cover property (pslverr);
endmodule
bind smisci_top smisci_props u_props (.core_clk, .reset_n, .paddr, .psel,
  .penable, .pwrite, .prdata, .pslverr, .pm_state, .battery_low_n,
  .wake_request, .wake_allowed, .sideband_wire_message, .sideband_ready,
  .sci_lines);
`default_nettype wire

// File: dv/smisci_sink.sv
// Core-side receiver of the sideband SMI message
`timescale 1ns/10ps
`default_nettype none
module smisci_sink (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Sync reset
  input wire logic msg, // Message valid
  input wire logic [3:0] delay, // Cycles before taking
  output logic ready, // Message taken
  output int count // Messages taken
);
  int wait_c;
  // Ready only ever answers a pending message, so stray ones show up
  always @(posedge core_clk) begin
    if (!reset_n) begin
      ready <= 1'b0;
      wait_c <= 0;
      count <= 0;
    end else begin
      ready <= msg && !ready && wait_c >= delay;
      wait_c <= (msg && !ready) ? wait_c + 1 : 0;
      if (msg && ready) count <= count + 1;
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the SMI/SCI event generator
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import smisci_pkg::*;
  logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, gpi = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, wake_allowed, msg, rdy, irq, err;
  logic [5:0] ev = 0;
  logic battery_low_n = 1, wake_request = 0;
  logic [3:0] smi_event = 0, delay = 0;
  logic [1:0] pm_state = 0;
  logic [6:0] sci_lines, e;
  int n_errors = 0, compares = 0, cnt, count, k;
  always #5 core_clk = ~core_clk;
  smisci_top dut (.core_clk, .reset_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .button_override(ev[0]),
    .rtc_alarm(ev[1]), .power_button(ev[2]), .global_release(ev[3]),
    .pm_timer_overflow(ev[4]), .bus0_pme(ev[5]), .battery_low_n, .gpi,
    .smi_event, .pm_state, .wake_request, .wake_allowed,
    .sideband_wire_message(msg), .sideband_ready(rdy), .sci_lines, .irq);
  smisci_sink sink (.core_clk, .reset_n, .msg, .delay, .ready(rdy),
    .count);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int i = 0;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      n_errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    tick(10);
    reset_n <= 1'b1;
    rdc(OFS_CTL, 32'h4);
    rdc(OFS_STATE, 32'h20);
    chk(32'(err), 32'h0);
    // Every source but the GPIs and the software GPE fires with all enables off: status only, no interrupt
    @(posedge core_clk);
    ev <= 6'h3f;
    smi_event <= 4'hf;
    battery_low_n <= 1'b0;
    @(posedge core_clk);
    ev <= 6'h0;
    smi_event <= 4'h0;
    tick(3);
    rdc(OFS_STS, 32'hf007f);
    chk(count, 0);
    wr(OFS_STS, 32'hfffff);
    rdc(OFS_STS, 32'h0);
    pm_state <= PM_S4;
    wake_request <= 1'b1;
    tick(2);
    chk(32'(wake_allowed), 32'h0);
    battery_low_n <= 1'b1;
    tick(2);
    chk(32'(wake_allowed), 32'h1);
    pm_state <= PM_S0;
    // Each dual source under all four select/enable combinations
    wr(OFS_EN, 32'hf6);
    wr(OFS_IMSK, 32'h3);
    for (int m = 0; m < 4; m++) begin
      for (int b = 1; b < 8; b++) begin
        if (b == 3) continue;
        wr(OFS_CTL, m | 4);
        cnt = count;
        @(posedge core_clk);
        if (b == 6) battery_low_n <= 1'b0;
        else if (b < 6) ev[b] <= 1'b1;
        @(posedge core_clk);
        ev <= 6'h0;
        battery_low_n <= 1'b1;
        if (b == 7) wr(OFS_CTL, m | 12);
        tick(6);
        chk(32'(sci_lines), {25'h0, 6'h3c, m[0]});
        chk(count - cnt, 32'(m == 2));
        chk(32'(irq), 32'(m != 0));
        wr(OFS_STS, 32'hfffff);
        wr(OFS_ISTS, 32'h3);
        tick(2);
        chk(32'(sci_lines), 32'(LINE_IDLE));
      end
    end
    // Slow receiver; events while not re-armed must wait
    delay <= 4'h5;
    wr(OFS_IMSK, 32'h0);
    wr(OFS_EN, 32'h10000);
    wr(OFS_CTL, 32'h2);
    cnt = count;
    repeat (2) begin
      @(posedge core_clk);
      smi_event <= 4'h1;
      @(posedge core_clk);
      smi_event <= 4'h0;
      tick(12);
      chk(count - cnt, 1);
    end
    rdc(OFS_CTL, 32'h2);
    chk(32'(irq), 32'h0);
    wr(OFS_CTL, 32'h6);
    tick(12);
    chk(count - cnt, 2);
    wr(OFS_STS, 32'hfffff);
    wr(OFS_CTL, 32'h6);
    tick(12);
    chk(count - cnt, 2);
    rdc(OFS_ISTS, 32'h1);
    wr(OFS_IMSK, 32'h1);
    tick(2);
    chk(32'(irq), 32'h1);
    wr(OFS_ISTS, 32'h1);
    tick(2);
    chk(32'(irq), 32'h0);
    // GPI path: only route 10b with SCI selected, never SMI
    cnt = count;
    wr(OFS_EN, 32'h100);
    wr(OFS_ROUTE, 32'h1);
    wr(OFS_CTL, 32'h3);
    gpi <= 8'h1;
    tick(3);
    chk(32'(sci_lines), 32'(LINE_IDLE));
    wr(OFS_ROUTE, 32'h2);
    tick(3);
    chk(32'(sci_lines), 32'h79);
    wr(OFS_CTL, 32'h2);
    tick(6);
    chk(32'(sci_lines), 32'(LINE_IDLE));
    chk(count - cnt, 0);
    gpi <= 8'h0;
    wr(OFS_STS, 32'hfffff);
    // Line codes with and without APIC routing
    wr(OFS_EN, 32'h80);
    for (int a = 0; a < 2; a++) begin
      for (int c = 0; c < 8; c++) begin
        wr(OFS_CTL, 32'h9 | (a << 4) | (c << 8));
        tick(3);
        k = (a == 0 && c > 2) ? 0 : c;
        e = LINE_IDLE;
        if (k < 3) e[k] = 1'b1;
        else if (k < 7) e[k] = 1'b0;
        chk(32'(sci_lines), 32'(e));
      end
    end
    rdc(8'h40, 32'h0);
    chk(32'(err), 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
